// >>> rtl/spidc_port.sv
`timescale 1ns/100ps
// Functional notes
// - Receive data bits 15:8 hold a second byte only in DMA mode, else zero.
// - Transmit data bits 15:8 are a second byte only in DMA mode.
// - With edge enable set in continuous mode, each select edge sets a flag.
// - The select edge enable does nothing outside continuous mode.
// - With counter reset set, a select error clears the bit counter.
// - With counter reset clear, a select error keeps the bit count.
// - The serial clock period is 2 x (divider + 1) bus clocks, from a 6-bit divider field.
// - The transmit event fires after 1 to 4 bytes per threshold field.
// - The receive event fires at 1 to 3 held bytes, or at full for 11.
// - With transmit flush clear the transmit FIFO runs normally.
// - In the slave role, select leaving before a full byte flags an error, which interrupts when its mask bit is set.
// - Continuous master transfers keep select low while data remains.
// - While transmit flush is set, transmit FIFO writes are ignored.
module spidc_port (
   // Clock and reset
   input logic pclk,
   input logic presetn,
   // APB slave
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [31:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial pins, master role
   output logic mst_sclk,
   output logic mst_mosi,
   output logic mst_cs_n,
   input logic mst_miso,
   // Serial pins, slave role
   input logic slv_sclk,
   input logic slv_mosi,
   input logic slv_cs_n,
   output logic slv_miso,
   output logic slv_miso_en,
   // Interrupt
   output logic irq
);
   typedef struct packed {
      logic [15:0] div;
      logic [15:0] con;
      logic [15:0] ctrl;
      logic [spidc_pkg::ST_W-1:0] stat;
      logic [spidc_pkg::ST_W-1:0] mask;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic half;
      logic [7:0] lo;
      spidc_pkg::spidc_state_t st;
      logic [2:0] bitc;
      logic [7:0] sh;
      logic [1:0] txn;
      logic sclk;
      logic mosi;
      logic cs_n;
      logic miso;
      logic miso_en;
      logic cs_prev;
      logic sclk_prev;
      logic irq;
   } spidc_port_t;
   spidc_port_t q, d;

   spidc_fifo_if #(.W(spidc_pkg::BYTE_W), .DEPTH(spidc_pkg::FIFO_DEPTH)) txf();
   spidc_fifo_if #(.W(spidc_pkg::BYTE_W), .DEPTH(spidc_pkg::FIFO_DEPTH)) rxf();

   logic tick, acc, en, mst, dma, continuous_transfer_mode, tx_fifo_flush, rflush, csen, csrst;
   logic byte_done, cs_err, cs_line, cs_fall_ev, cs_rise_ev;
   logic slv_rise, slv_fall, rx_hit;
   logic [1:0] thr;
   logic [7:0] rx_byte, next_tx;
   logic [spidc_pkg::ST_W-1:0] ev, w1c;

   // Byte queues in both directions
   spidc_fifo #(.W(spidc_pkg::BYTE_W), .DEPTH(spidc_pkg::FIFO_DEPTH))
      u_txf (.pclk(pclk), .presetn(presetn), .f(txf.fifo));
   spidc_fifo #(.W(spidc_pkg::BYTE_W), .DEPTH(spidc_pkg::FIFO_DEPTH))
      u_rxf (.pclk(pclk), .presetn(presetn), .f(rxf.fifo));

   // Serial clock half-period timer
   spidc_clkdiv #(.DW(spidc_pkg::DIV_W)) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .run(q.st == spidc_pkg::SPIDC_SHIFT || q.st == spidc_pkg::SPIDC_GAP),
      .div(q.div[spidc_pkg::DIV_W-1:0]),
      .tick(tick)
   );

   // Configuration decode
   assign en = q.ctrl[spidc_pkg::EN_BIT];
   assign mst = q.ctrl[spidc_pkg::MST_BIT];
   assign dma = q.ctrl[spidc_pkg::DMA_BIT];
   assign continuous_transfer_mode = q.con[spidc_pkg::CONTINUOUS_TRANSFER_MODE_BIT];
   assign tx_fifo_flush = q.con[spidc_pkg::TX_FIFO_FLUSH_BIT];
   assign rflush = q.con[spidc_pkg::RFLUSH_BIT];
   assign thr = q.con[spidc_pkg::THR_LSB+:2];
   assign csen = q.div[spidc_pkg::CSIRQ_BIT];
   assign csrst = q.div[spidc_pkg::CSRST_BIT];
   assign acc = psel && penable && !q.pready;
   assign cs_line = mst ? q.cs_n : slv_cs_n;
   assign slv_rise = slv_sclk && !q.sclk_prev;
   assign slv_fall = !slv_sclk && q.sclk_prev;

   always_comb
   begin
      d = q;
      txf.push = 1'b0;
      txf.pop = 1'b0;
      txf.wdata = '0;
      rxf.push = 1'b0;
      rxf.pop = 1'b0;
      rxf.wdata = '0;
      txf.flush = tx_fifo_flush;
      rxf.flush = rflush;
      byte_done = 1'b0;
      cs_err = 1'b0;
      rx_byte = '0;
      w1c = '0;
      ev = '0;
      next_tx = txf.empty ? 8'h00 : txf.rdata;
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      // Bus side: every access answers after one wait cycle, DMA data two
      if (acc)
      begin
         if (dma && !q.half &&
             (paddr == spidc_pkg::ADDR_RX || paddr == spidc_pkg::ADDR_TX))
         begin
            // First half of a half-word FIFO access moves the low byte
            d.half = 1'b1;
            if (pwrite && paddr == spidc_pkg::ADDR_TX)
            begin
               txf.push = !tx_fifo_flush;
               txf.wdata = pwdata[7:0];
            end
            else if (!pwrite && paddr == spidc_pkg::ADDR_RX)
            begin
               rxf.pop = 1'b1;
               d.lo = rxf.empty ? 8'h00 : rxf.rdata;
            end
         end
         else
         begin
            d.half = 1'b0;
            d.pready = 1'b1;
            d.prdata = '0;
            if (paddr == spidc_pkg::ADDR_RX)
            begin
               if (!pwrite)
               begin
                  rxf.pop = 1'b1;
                  d.prdata[7:0] = dma ? q.lo : rxf.rdata & {8{!rxf.empty}};
                  if (dma)
                     d.prdata[15:8] = rxf.empty ? 8'h00 : rxf.rdata;
               end
            end
            else if (paddr == spidc_pkg::ADDR_TX)
            begin
               if (pwrite)
               begin
                  txf.push = !tx_fifo_flush;
                  txf.wdata = dma ? pwdata[15:8] : pwdata[7:0];
               end
            end
            else if (paddr == spidc_pkg::ADDR_DIV)
            begin
               if (pwrite)
                  d.div = pwdata[15:0] & spidc_pkg::DIV_RMASK;
               d.prdata[15:0] = q.div;
            end
            else if (paddr == spidc_pkg::ADDR_CON)
            begin
               if (pwrite)
                  d.con = pwdata[15:0];
               d.prdata[15:0] = q.con;
            end
            else if (paddr == spidc_pkg::ADDR_CTRL)
            begin
               if (pwrite)
                  d.ctrl = pwdata[15:0];
               d.prdata[15:0] = q.ctrl;
            end
            else if (paddr == spidc_pkg::ADDR_STAT)
            begin
               if (pwrite)
                  w1c = pwdata[spidc_pkg::ST_W-1:0];
               d.prdata[spidc_pkg::ST_W-1:0] = q.stat;
               d.prdata[spidc_pkg::ST_TXCNT_LSB+:3] = txf.count;
               d.prdata[spidc_pkg::ST_RXCNT_LSB+:3] = rxf.count;
            end
            else if (paddr == spidc_pkg::ADDR_MASK)
            begin
               if (pwrite)
                  d.mask = pwdata[spidc_pkg::ST_W-1:0];
               d.prdata[spidc_pkg::ST_W-1:0] = q.mask;
            end
            else
               d.pslverr = 1'b1;
         end
      end
      // Master engine, MSB first, sample on rising serial edge
      d.sclk_prev = slv_sclk;
      case (q.st)
         spidc_pkg::SPIDC_IDLE:
         begin
            d.cs_n = 1'b1;
            d.sclk = 1'b0;
            if (en && mst && !txf.empty && !tx_fifo_flush)
            begin
               txf.pop = 1'b1;
               d.sh = txf.rdata;
               d.mosi = txf.rdata[7];
               d.cs_n = 1'b0;
               d.bitc = '0;
               d.st = spidc_pkg::SPIDC_SHIFT;
            end
         end
         spidc_pkg::SPIDC_SHIFT:
         begin
            if (tick && !q.sclk)
            begin
               d.sclk = 1'b1;
               d.sh = {q.sh[6:0], mst_miso};
            end
            else if (tick)
            begin
               d.sclk = 1'b0;
               if (q.bitc == spidc_pkg::LAST_BIT)
               begin
                  byte_done = 1'b1;
                  rx_byte = q.sh;
                  d.bitc = '0;
                  if (continuous_transfer_mode && !txf.empty && !tx_fifo_flush)
                  begin
                     // Select stays low while data remains
                     txf.pop = 1'b1;
                     d.sh = txf.rdata;
                     d.mosi = txf.rdata[7];
                  end
                  else
                  begin
                     d.cs_n = 1'b1;
                     d.st = spidc_pkg::SPIDC_GAP;
                  end
               end
               else
               begin
                  d.bitc = q.bitc + 3'h1;
                  d.mosi = q.sh[7];
               end
            end
         end
         spidc_pkg::SPIDC_GAP:
            // One serial half period of stall between transfers
            if (tick)
               d.st = spidc_pkg::SPIDC_IDLE;
         default:
            d.st = spidc_pkg::SPIDC_IDLE;
      endcase
      if (!en || !mst)
      begin
         d.st = spidc_pkg::SPIDC_IDLE;
         d.cs_n = 1'b1;
         d.sclk = 1'b0;
      end
      // Slave engine, pins taken as synchronous
      d.miso_en = en && !mst && !slv_cs_n;
      if (en && !mst)
      begin
         if (!slv_cs_n && q.cs_prev && q.bitc == '0)
         begin
            txf.pop = 1'b1;
            d.sh = next_tx;
            d.miso = next_tx[7];
         end
         else if (!slv_cs_n && slv_rise)
         begin
            if (q.bitc == spidc_pkg::LAST_BIT)
            begin
               byte_done = 1'b1;
               rx_byte = {q.sh[6:0], slv_mosi};
               d.bitc = '0;
               txf.pop = 1'b1;
               d.sh = next_tx;
               d.miso = next_tx[7];
            end
            else
            begin
               d.bitc = q.bitc + 3'h1;
               d.sh = {q.sh[6:0], slv_mosi};
            end
         end
         else if (!slv_cs_n && slv_fall)
            d.miso = q.sh[7];
         if (slv_cs_n && !q.cs_prev && q.bitc != '0)
         begin
            cs_err = 1'b1;
            // Keeping the count lets a resumed frame finish the byte
            if (csrst)
               d.bitc = '0;
            else
               d.bitc = q.bitc;
         end
      end
      // Received bytes; a full queue drops the new byte
      rx_hit = byte_done && !rflush && (rxf.count >= {1'b0, thr});
      if (byte_done && !rflush)
      begin
         rxf.push = 1'b1;
         rxf.wdata = rx_byte;
      end
      // Transmit event after the programmed number of bytes
      if (byte_done)
      begin
         if (q.txn == thr)
         begin
            ev[spidc_pkg::ST_TX] = 1'b1;
            d.txn = '0;
         end
         else
            d.txn = q.txn + 2'h1;
      end
      ev[spidc_pkg::ST_RX] = rx_hit;
      ev[spidc_pkg::ST_CS_ABORT_ERROR_FLAG] = cs_err;
      // Select edges only count in continuous mode with the enable
      d.cs_prev = cs_line;
      cs_fall_ev = continuous_transfer_mode && csen && q.cs_prev && !cs_line;
      cs_rise_ev = continuous_transfer_mode && csen && !q.cs_prev && cs_line;
      ev[spidc_pkg::ST_CSFALL] = cs_fall_ev;
      ev[spidc_pkg::ST_CSRISE] = cs_rise_ev;
      // Set wins over a same-cycle write-one clear
      d.stat = (q.stat & ~w1c) | ev;
      d.irq = |(d.stat & d.mask);
   end

   // All state in one register; zero after reset except select and its last sample, which reset high
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         q <= '0;
         q.cs_n <= 1'b1;
         q.cs_prev <= 1'b1;
      end
      else
         q <= d;

   // Outputs straight from flip-flops
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign mst_sclk = q.sclk;
   assign mst_mosi = q.mosi;
   assign mst_cs_n = q.cs_n;
   assign slv_miso = q.miso;
   assign slv_miso_en = q.miso_en;
   assign irq = q.irq;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_RX_UPPER_ZERO: assert property (
      pready && !pwrite && paddr == spidc_pkg::ADDR_RX && !dma
      |-> prdata[15:8] == 8'h00)
      else $error("Receive upper byte not zero outside DMA");
   AST_TX_FLUSH_DROP: assert property (
      tx_fifo_flush |-> !txf.push)
      else $error("Transmit FIFO written during flush");
   AST_CS_FALL_FLAG: assert property (
      continuous_transfer_mode && csen && $fell(cs_line) |=> q.stat[spidc_pkg::ST_CSFALL])
      else $error("Select falling edge not flagged");
   AST_CS_NO_EDGE_IRQ: assert property (
      !(continuous_transfer_mode && csen) |-> !cs_fall_ev && !cs_rise_ev)
      else $error("Select edge event without enable");
   AST_CS_ABORT_ERROR_FLAG_CLEAR: assert property (
      cs_err && csrst |=> q.bitc == 3'h0)
      else $error("Bit counter not cleared after select error");
   AST_CS_ABORT_ERROR_FLAG_KEEP: assert property (
      cs_err && !csrst |=> $stable(q.bitc))
      else $error("Bit counter changed after select error");
   AST_CS_ABORT_ERROR_FLAG_FLAG: assert property (
      cs_err |=> q.stat[spidc_pkg::ST_CS_ABORT_ERROR_FLAG] ##1 irq || !q.mask[2])
      else $error("Select error not flagged");
   AST_SCLK_ON_TICK: assert property (
      $changed(mst_sclk) && $past(q.st) == spidc_pkg::SPIDC_SHIFT
      |-> $past(tick))
      else $error("Serial clock moved without divider tick");
   AST_DMA_TWO_STEP: assert property (
      acc && dma && !q.half && paddr == spidc_pkg::ADDR_TX
      |=> !pready ##1 pready)
      else $error("DMA half-word access not two steps");
   AST_CONTINUOUS_TRANSFER_MODE_HOLD: assert property (
      byte_done && mst && continuous_transfer_mode && !txf.empty && !tx_fifo_flush |=> !mst_cs_n)
      else $error("Select released with data pending");
   AST_DIV_RSV_ZERO: assert property (
      pready && !pwrite && paddr == spidc_pkg::ADDR_DIV
      |-> prdata[31:9] == 23'h0)
      else $error("Reserved divider bits not zero");
   COV_MASTER_BYTE: cover property (byte_done && mst);
   COV_SLAVE_ERROR: cover property (cs_err);
   COV_DMA_READ: cover property (acc && dma && q.half && !pwrite);
endmodule : spidc_port

// >>> pkg/spidc_pkg.sv
package spidc_pkg;
   // Register byte addresses
   localparam logic [31:0] ADDR_RX = 32'h4002c004;
   localparam logic [31:0] ADDR_TX = 32'h4002c008;
   localparam logic [31:0] ADDR_DIV = 32'h4002c00c;
   localparam logic [31:0] ADDR_CON = 32'h4002c010;
   localparam logic [31:0] ADDR_STAT = 32'h4002c014;
   localparam logic [31:0] ADDR_MASK = 32'h4002c018;
   localparam logic [31:0] ADDR_CTRL = 32'h4002c01c;
   // Reset value and readable bits of the divider register
   localparam logic [15:0] REG_RST = 16'h0000;
   localparam logic [15:0] DIV_RMASK = 16'h01ff;
   // Divider register fields
   localparam int DIV_W = 6;
   localparam int CSRST_BIT = 7;
   localparam int CSIRQ_BIT = 8;
   // Configuration register fields
   localparam int THR_LSB = 14;
   localparam int TX_FIFO_FLUSH_BIT = 13;
   localparam int RFLUSH_BIT = 12;
   localparam int CONTINUOUS_TRANSFER_MODE_BIT = 11;
   // Control register fields
   localparam int EN_BIT = 0;
   localparam int MST_BIT = 1;
   localparam int DMA_BIT = 2;
   // Status register: sticky events, then fill levels
   localparam int ST_TX = 0;
   localparam int ST_RX = 1;
   localparam int ST_CS_ABORT_ERROR_FLAG = 2;
   localparam int ST_CSFALL = 3;
   localparam int ST_CSRISE = 4;
   localparam int ST_W = 5;
   localparam int ST_TXCNT_LSB = 5;
   localparam int ST_RXCNT_LSB = 8;
   // Serial framing and FIFO size
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 4;
   localparam logic [2:0] LAST_BIT = 3'h7;
   // Serial engine states
   typedef enum logic [1:0] {
      SPIDC_IDLE = 2'b00,
      SPIDC_SHIFT = 2'b01,
      SPIDC_GAP = 2'b10
   } spidc_state_t;
endpackage : spidc_pkg

// >>> pkg/spidc_fifo_if.sv
`timescale 1ns/100ps
interface spidc_fifo_if #(
   parameter int W = 8,
   parameter int DEPTH = 4
);
   localparam int CW = $clog2(DEPTH + 1);
   // Fill side, drain side and flush
   logic push;
   logic pop;
   logic flush;
   logic [W-1:0] wdata;
   logic [W-1:0] rdata;
   logic [CW-1:0] count;
   logic full;
   logic empty;
   modport fifo (input push, pop, flush, wdata,
                 output rdata, count, full, empty);
   modport user (output push, pop, flush, wdata,
                 input rdata, count, full, empty);
endinterface : spidc_fifo_if

// >>> rtl/spidc_fifo.sv
`timescale 1ns/100ps
module spidc_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input logic pclk,
   input logic presetn,
   // FIFO port
   spidc_fifo_if.fifo f
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] cnt;
   } spidc_fifo_t;
   spidc_fifo_t q, d;
   logic do_push, do_pop;

   // Pointers wrap naturally, so depth must be a power of two
   always_comb
   begin
      d = q;
      do_push = f.push && (q.cnt != CW'(DEPTH));
      do_pop = f.pop && (q.cnt != '0);
      if (f.flush)
      begin
         d.wp = '0;
         d.rp = '0;
         d.cnt = '0;
      end
      else
      begin
         if (do_push)
         begin
            d.mem[q.wp] = f.wdata;
            d.wp = q.wp + PW'(1);
         end
         if (do_pop)
            d.rp = q.rp + PW'(1);
         d.cnt = q.cnt + CW'(do_push) - CW'(do_pop);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         q <= '0;
      else
         q <= d;

   // Head of queue is visible before the pop
   assign f.rdata = q.mem[q.rp];
   assign f.count = q.cnt;
   assign f.full = (q.cnt == CW'(DEPTH));
   assign f.empty = (q.cnt == '0);
endmodule : spidc_fifo

// >>> rtl/spidc_clkdiv.sv
`timescale 1ns/100ps
module spidc_clkdiv #(
   parameter int DW = 6
) (
   // Clock and reset
   input logic pclk,
   input logic presetn,
   // Control
   input logic run,
   input logic [DW-1:0] div,
   // One pulse per serial half period
   output logic tick
);
   typedef struct packed {
      logic [DW-1:0] cnt;
   } spidc_div_t;
   spidc_div_t q, d;

   // Count restarts whenever the engine is idle, so phase is clean
   always_comb
   begin
      d = q;
      tick = run && (q.cnt == div);
      if (!run || tick)
         d.cnt = '0;
      else
         d.cnt = q.cnt + DW'(1);
   end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         q <= '0;
      else
         q <= d;
endmodule : spidc_clkdiv

// >>> test/spidc_slave_model.sv
`timescale 1ns/100ps
module spidc_slave_model (
   // Serial pins of the master under test
   input wire logic sclk,
   input wire logic mosi,
   input wire logic cs_n,
   output logic miso,
   // Observation for the bench
   output logic [15:0] got,
   output int nbytes,
   output int per
);
   logic [7:0] sh_in;
   logic [7:0] sh_out;
   int bitn;
   int t_rise;

   initial
   begin
      miso = 1'b0;
      got = 16'h0000;
      nbytes = 0;
      per = 0;
      bitn = 0;
      t_rise = 0;
      sh_in = 8'h00;
      sh_out = 8'h00;
   end

   // Mode 0: the first bit must stand before the first rise
   always @(negedge cs_n)
   begin
      sh_out = 8'ha5 + 8'(nbytes);
      miso = sh_out[7];
      bitn = 0;
   end

   // Sample on rise; period measured only inside a byte
   always @(posedge sclk)
   begin
      if (bitn > 0) per = int'($time) - t_rise;
      t_rise = int'($time);
      sh_in = {sh_in[6:0], mosi};
      bitn++;
      if (bitn == 8)
      begin
         got = {got[7:0], sh_in};
         nbytes++;
         bitn = 0;
      end
   end

   // Shift on fall; a continuous frame reloads after the eighth bit
   always @(negedge sclk)
   begin
      if (bitn == 0) sh_out = 8'ha5 + 8'(nbytes);
      else sh_out = {sh_out[6:0], 1'b0};
      miso = sh_out[7];
   end

   // Released line must not look like valid data
   always @(posedge cs_n) miso = ~miso;
endmodule : spidc_slave_model

// >>> test/tb.sv
`timescale 1ns/100ps
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] seed;
   logic pready, pslverr, sclk, mosi, cs_n, miso, irq;
   logic s_sclk = 1'b0;
   logic s_mosi = 1'b0;
   logic s_cs_n = 1'b1;
   logic [15:0] got;
   logic [7:0] sent;
   logic [32:0] e_v, m_v;
   logic [32:0] exp_q[$];
   logic [32:0] msk_q[$];
   int nbytes, per, n0, div_v;
   int err_count = 0;
   int n_compared = 0;
   int cyc = 0;

   always #4 pclk = ~pclk;

   // Model answers the master role; the bench drives the slave role
   spidc_port spidc_port_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mst_sclk(sclk), .mst_mosi(mosi),
      .mst_cs_n(cs_n), .mst_miso(miso), .slv_sclk(s_sclk),
      .slv_mosi(s_mosi), .slv_cs_n(s_cs_n), .slv_miso(), .slv_miso_en(),
      .irq(irq));
   spidc_slave_model spidc_slave_model_inst (.sclk(sclk), .mosi(mosi),
      .cs_n(cs_n), .miso(miso), .got(got), .nbytes(nbytes), .per(per));

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask : check

   task automatic results;
      if (err_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results

   // Idle edge first, so a release is never overwritten in its time step
   task automatic apb(input logic [31:0] a, d, input logic w);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwdata <= d;
      pwrite <= w;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do @(posedge pclk); while (pready !== 1'b1 && ++i < 50);
      if (i >= 50) err_count++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [31:0] a, d);
      apb(a, d, 1'b1);
   endtask : wr

   task automatic rdm(input logic [31:0] a, input logic [32:0] e, m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      apb(a, 32'h0, 1'b0);
   endtask : rdm

   task automatic irq_is(input logic e);
      @(negedge pclk);
      check(33'(irq), 33'(e));
   endtask : irq_is

   task automatic wait_frame;
      int i;
      i = 0;
      while (cs_n !== 1'b0 && i < 4000) begin @(negedge pclk); i++; end
      while (cs_n !== 1'b1 && i < 4000) begin @(negedge pclk); i++; end
      if (i >= 4000) err_count++;
      repeat (8) @(posedge pclk);
   endtask : wait_frame

   // Random word to the transmit register; upper byte only counts in DMA
   task automatic send(input logic dma);
      seed = nxt(seed);
      n0 = nbytes;
      wr(spidc_pkg::ADDR_TX, {16'h0, seed[15:0]});
      wait_frame();
      check(33'(nbytes - n0), dma ? 33'h2 : 33'h1);
      check(33'(per), 33'(16 * (div_v + 1)));
      if (dma) check(33'(got), 33'({seed[7:0], seed[15:8]}));
      else check(33'(got[7:0]), 33'(seed[7:0]));
      sent = sent + (dma ? 8'h02 : 8'h01);
   endtask : send

   // Drive n bits of v to the slave pins, MSB first, mode 0
   task automatic sbits(input logic [7:0] v, input int n);
      for (int b = 7; b > 7 - n; b--)
      begin
         @(posedge pclk) s_mosi <= v[b];
         repeat (2) @(posedge pclk);
         s_sclk <= 1'b1;
         repeat (2) @(posedge pclk);
         s_sclk <= 1'b0;
      end
   endtask : sbits

   // Read monitor: oldest note against the answer, at the ready edge
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1 && !pwrite &&
         exp_q.size() > 0)
      begin
         e_v = exp_q.pop_front();
         m_v = msk_q.pop_front();
         check({pslverr, prdata} & m_v, e_v & m_v);
      end
   end

   // Hang guard
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         err_count++;
         results();
      end
   end

   initial
   begin
      seed = 32'hd4f2;
      sent = 8'h00;
      div_v = 1;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rdm(spidc_pkg::ADDR_RX, 33'h0, {33{1'b1}});
      rdm(spidc_pkg::ADDR_DIV, 33'h0, {33{1'b1}});
      rdm(spidc_pkg::ADDR_CON, 33'h0, {33{1'b1}});
      rdm(32'h4002c020, 33'h100000000, 33'h100000000);
      wr(spidc_pkg::ADDR_DIV, 32'hffff);
      rdm(spidc_pkg::ADDR_DIV, {17'h0, spidc_pkg::DIV_RMASK},
         {33{1'b1}});
      wr(spidc_pkg::ADDR_DIV, 32'h0181); // Counter reset kept set
      wr(spidc_pkg::ADDR_MASK, 32'h1f);
      wr(spidc_pkg::ADDR_CTRL, 32'h3);
      // Every threshold: events only once t+1 bytes went through
      for (int t = 0; t < 4; t++)
      begin
         wr(spidc_pkg::ADDR_STAT, 32'h1f);
         irq_is(1'b0);
         wr(spidc_pkg::ADDR_CON, 32'(t) << 14);
         for (int k = 0; k <= t; k++)
         begin
            if (k == t) rdm(spidc_pkg::ADDR_STAT, 33'h0, 33'h3);
            send(1'b0);
         end
         rdm(spidc_pkg::ADDR_STAT, 33'h3, 33'h1f);
         irq_is(1'b1);
         wr(spidc_pkg::ADDR_MASK, 32'h0);
         irq_is(1'b0);
         wr(spidc_pkg::ADDR_MASK, 32'h1f);
         for (int k = t; k >= 0; k--)
            rdm(spidc_pkg::ADDR_RX, {25'h0, 8'ha5 + sent - 8'(k + 1)},
               {33{1'b1}});
      end
      // DMA half-words in one continuous frame
      div_v = 3;
      wr(spidc_pkg::ADDR_DIV, 32'h0183);
      wr(spidc_pkg::ADDR_CON, 32'h0800); // Threshold zero for DMA
      wr(spidc_pkg::ADDR_CTRL, 32'h7);
      wr(spidc_pkg::ADDR_STAT, 32'h1f);
      send(1'b1);
      rdm(spidc_pkg::ADDR_STAT, 33'h18, 33'h18);
      rdm(spidc_pkg::ADDR_RX, {17'h0, 8'ha5 + sent - 8'h1,
         8'ha5 + sent - 8'h2}, {33{1'b1}});
      // Flush set drops writes; cleared again runs normally
      wr(spidc_pkg::ADDR_CTRL, 32'h3);
      wr(spidc_pkg::ADDR_CON, 32'h2000);
      n0 = nbytes;
      wr(spidc_pkg::ADDR_TX, 32'h5a);
      rdm(spidc_pkg::ADDR_STAT, 33'h0, 33'he0);
      repeat (60) @(posedge pclk);
      check(33'(nbytes - n0), 33'h0);
      wr(spidc_pkg::ADDR_CON, 32'h0);
      send(1'b0);
      // Slave role: a cut byte is an error; counter reset sets the resume
      wr(spidc_pkg::ADDR_CON, 32'h1000); // Drop the byte left in receive
      wr(spidc_pkg::ADDR_CON, 32'h0);
      wr(spidc_pkg::ADDR_CTRL, 32'h1);
      for (int r = 1; r >= 0; r--)
      begin
         wr(spidc_pkg::ADDR_DIV, 32'(r) << spidc_pkg::CSRST_BIT);
         wr(spidc_pkg::ADDR_STAT, 32'h1f);
         s_cs_n <= 1'b0;
         sbits(8'hc6, 3);
         @(posedge pclk) s_cs_n <= 1'b1;
         rdm(spidc_pkg::ADDR_STAT, 33'h4, 33'h4);
         check(33'(irq), 33'h1);
         s_cs_n <= 1'b0;
         sbits(r ? 8'h3b : 8'(8'hc6 << 3), r ? 8 : 5);
         @(posedge pclk) s_cs_n <= 1'b1;
         rdm(spidc_pkg::ADDR_RX, {25'h0, r ? 8'h3b : 8'hc6},
            {33{1'b1}});
      end
      repeat (10) @(posedge pclk);
      results();
   end
endmodule : tb
